// File: ext_ctl_defs.svh
// constants for the external bus control-signal block
`ifndef EXT_CTL_DEFS_SVH
`define EXT_CTL_DEFS_SVH

// region count and per-region field widths
`define REGION_COUNT    7
`define REGION_IDX_W    3
`define BASE_W          20
`define PHASE_CNT_W     4
`define WAIT_CNT_W      5

// input sampling modes for the command-extend and wait inputs
`define SMP_IGNORE      2'h0
`define SMP_SYNC        2'h1
`define SMP_ASYNC       2'h2

// external device data width codes
`define DEV_WIDTH_8     2'h0
`define DEV_WIDTH_16    2'h1
`define DEV_WIDTH_32    2'h2

// byte lane enable timing codes
`define BCT_CHIP_SEL    2'h0
`define BCT_CONTROL     2'h1
`define BCT_WRITE_ONLY  2'h2

// byte lane enable and user chip select idle values (all inactive)
`define BC_IDLE         4'hf
`define CS_IDLE         7'h7f

`endif

// File: ext_ctl_pkg.sv
// types shared by the external bus control-signal modules
package ext_ctl_pkg;

	// access sequencer phases
	typedef enum logic [2:0] {
		ph_idle,
		ph_addr,
		ph_cmd,
		ph_access,
		ph_recover,
		ph_released
	} phase_t;

	// state of one input sampler
	typedef struct packed {
		logic sync_q;    // single-stage sample
		logic meta_q;    // first stage of the async pair
		logic async_q;   // second stage of the async pair
	} sampler_state_t;

endpackage : ext_ctl_pkg

// File: ext_sample_if.sv
// carrier between the sequencer and an input sampler
`timescale 1ns/1ns
interface ext_sample_if;
	logic       pin;      // raw input level from the pad
	logic [1:0] mode;     // sampling mode chosen for the active region
	logic       sampled;  // value the sequencer may act on this edge

	modport sampler (input pin, input mode, output sampled);
	modport user    (output pin, output mode, input sampled);
endinterface : ext_sample_if

// File: ext_input_sampler.sv
// sync or async sampler for the command-extend and wait inputs
`timescale 1ns/1ns
`include "ext_ctl_defs.svh"
module ext_input_sampler
	import ext_ctl_pkg::*;
(
	// clock and reset
	input wire logic     clock,
	input wire logic     rst_n,
	// sequencer side
	ext_sample_if.sampler port_if
);

	sampler_state_t st;       // registered state
	sampler_state_t next_st;  // next state

	// both paths sample every edge; the mode only picks which result is used
	always_comb begin
		next_st         = st;
		next_st.sync_q  = port_if.pin;
		next_st.meta_q  = port_if.pin;
		// only the second stage reads the first, keeping metastability contained
		next_st.async_q = st.meta_q;
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// sync uses last edge's sample, async the one taken an edge earlier
	always_comb begin
		case (port_if.mode)
			`SMP_SYNC:  port_if.sampled = st.sync_q;
			`SMP_ASYNC: port_if.sampled = st.async_q;
			default:    port_if.sampled = 1'b0;
		endcase
	end

endmodule : ext_input_sampler

// File: ext_region_decoder.sv
// address region match with fixed priority for overlapping regions
`timescale 1ns/1ns
`include "ext_ctl_defs.svh"
module ext_region_decoder
	import ext_ctl_pkg::*;
#(
	parameter int REGIONS = `REGION_COUNT
) (
	// address under test
	input  wire logic [31:0]               addr,
	// per-region setup
	input  wire logic [REGIONS-1:0]        region_enable,
	input  wire logic [REGIONS*`BASE_W-1:0] region_base,
	input  wire logic [REGIONS*`BASE_W-1:0] region_mask,
	// result
	output logic                           hit,
	output logic [`REGION_IDX_W-1:0]       index
);

	logic [REGIONS-1:0] match;  // raw per-region match

	// a set mask bit means that address bit must equal the base bit
	for (genvar r = 0; r < REGIONS; r++) begin : g_match
		assign match[r] = region_enable[r] &&
			(((addr[31:12] ^ region_base[r*`BASE_W +: `BASE_W])
			  & region_mask[r*`BASE_W +: `BASE_W]) == '0);
	end

	// lowest number wins: scan downward so the last hit is the lowest
	always_comb begin
		hit   = 1'b0;
		index = '0;
		for (int r = REGIONS - 1; r >= 0; r--) begin
			if (match[r]) begin
				hit   = 1'b1;
				index = r[`REGION_IDX_W-1:0];
			end
		end
	end

endmodule : ext_region_decoder

// File: ext_bus_control.sv
// external bus control-signal sequencer: strobes, byte lanes, selects, release
//
// Behaviour
// - address latch strobe marks muxed address
// - address latch strobe length is programmable
// - demultiplexed regions keep the strobe low
// - byte lane enables follow device width
// - lowest lane enable carries lowest byte
// - three byte-lane timings: select, control, write
// - command-extend input lengthens command phase
// - per-region ignore, sync or async extension
// - extension only after programmed command cycles
// - sync sample acted on next edge
// - async sample acted on second edge
// - wait input adds wait states, per region
// - per-region wait polarity select
// - per-region sync or async wait sampling
// - sync wait sample evaluated next edge
// - async wait adds one synchronising cycle
// - seven active-low user chip selects
// - global select combines chosen user selects
// - lowest matching region wins on overlap
// - release request, acknowledge and ownership request
// - muxed: address first, then data or input
`timescale 1ns/1ns
`include "ext_ctl_defs.svh"
module ext_bus_control
	import ext_ctl_pkg::*;
#(
	parameter int REGIONS = `REGION_COUNT
) (
	// clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	// internal access request
	input  wire logic                           req_valid,
	output logic                                req_ready,
	input  wire logic                           req_write,
	input  wire logic [31:0]                    req_addr,
	input  wire logic [31:0]                    req_wdata,
	input  wire logic [3:0]                     req_byte_en,
	output logic                                resp_done,
	output logic                                resp_error,
	output logic [31:0]                         resp_rdata,
	// region address setup
	input  wire logic [REGIONS-1:0]             region_enable,
	input  wire logic [REGIONS*`BASE_W-1:0]     region_base,
	input  wire logic [REGIONS*`BASE_W-1:0]     region_mask,
	input  wire logic [REGIONS-1:0]             global_select_mask,
	// region bus control
	input  wire logic [REGIONS-1:0]             region_muxed,
	input  wire logic [REGIONS*2-1:0]           region_dev_width,
	input  wire logic [REGIONS*2-1:0]           region_bc_timing,
	input  wire logic [REGIONS*2-1:0]           cmd_extend_sample_mode,
	input  wire logic [REGIONS-1:0]             wait_enable,
	input  wire logic [REGIONS-1:0]             wait_polarity_select,
	input  wire logic [REGIONS-1:0]             wait_async,
	// region access parameters
	input  wire logic [REGIONS*`PHASE_CNT_W-1:0] ale_cycles,
	input  wire logic [REGIONS*`PHASE_CNT_W-1:0] cmd_phase_cycles,
	input  wire logic [REGIONS*`WAIT_CNT_W-1:0]  read_wait_cycles,
	input  wire logic [REGIONS*`WAIT_CNT_W-1:0]  write_wait_cycles,
	// address and shared address/data lines
	output logic [23:0]                         addr_out,
	output logic                                addr_oe,
	output logic [31:0]                         ad_out,
	output logic                                ad_oe,
	input  wire logic [31:0]                    ad_in,
	// strobes and selects
	output logic                                ale,
	output logic                                rd_n,
	output logic                                rd_wr_n,
	output logic [3:0]                          byte_lane_enable_n,
	output logic [REGIONS-1:0]                  user_chip_select_n,
	output logic                                global_chip_select_n,
	// external extension inputs
	input  wire logic                           cmd_extend_input,
	input  wire logic                           wait_input,
	// bus release handshake
	input  wire logic                           release_req_n,
	output logic                                bus_release_ack_n,
	output logic                                bus_ownership_request_n
);

	// whole sequencer state
	typedef struct packed {
		phase_t                    phase;   // current access phase
		logic [`WAIT_CNT_W-1:0]    count;   // cycles left in the phase
		logic [`REGION_IDX_W-1:0]  region;  // region of the access
		logic                      write;   // access direction
		logic [31:0]               addr;    // latched address
		logic [31:0]               wdata;   // latched write data
		logic [3:0]                bc_n;    // lane pattern, active low
		logic [31:0]               rdata;   // captured read data
		logic                      done;    // one-cycle completion
		logic                      error;   // one-cycle no-region answer
	} seq_state_t;

	seq_state_t st;       // registered state
	seq_state_t next_st;  // next state

	logic                     dec_hit;    // request address hits a region
	logic [`REGION_IDX_W-1:0] dec_index;  // winning region
	logic                     cur_muxed;  // active region is multiplexed
	logic                     cmd_ext;    // extension request seen by logic
	logic                     wait_act;   // wait request seen by logic
	logic [3:0]               lane_n;     // lane pattern for the new request
	logic [1:0]               new_width;  // width of the requested region
	logic                     strobe_on;  // rd or write strobe active
	logic                     select_on;  // chip select window

	// both samplers run all the time; the region only picks the mode
	ext_sample_if cmd_if ();   // command-extend sampler link
	ext_sample_if wait_if ();  // wait sampler link

	// region decode of the incoming request
	ext_region_decoder #(
		.REGIONS (REGIONS)
	) u_decoder (
		.addr          (req_addr),
		.region_enable (region_enable),
		.region_base   (region_base),
		.region_mask   (region_mask),
		.hit           (dec_hit),
		.index         (dec_index)
	);

	assign cmd_if.pin  = cmd_extend_input;
	assign cmd_if.mode = cmd_extend_sample_mode[st.region*2 +: 2];
	ext_input_sampler u_cmd_sampler (
		.clock   (clock),
		.rst_n   (rst_n),
		.port_if (cmd_if.sampler)
	);

	// wait sampler, ignored when the region disables wait
	assign wait_if.pin  = wait_input;
	assign wait_if.mode = !wait_enable[st.region] ? `SMP_IGNORE :
		(wait_async[st.region] ? `SMP_ASYNC : `SMP_SYNC);
	ext_input_sampler u_wait_sampler (
		.clock   (clock),
		.rst_n   (rst_n),
		.port_if (wait_if.sampler)
	);

	assign cur_muxed = region_muxed[st.region];
	assign cmd_ext   = cmd_if.sampled;
	// polarity bit set means a high level requests wait states
	assign wait_act  = (wait_if.mode != `SMP_IGNORE) &&
		(wait_if.sampled == wait_polarity_select[st.region]);

	// lane pattern by device width, lane 0 is always the low byte
	always_comb begin
		new_width = region_dev_width[dec_index*2 +: 2];
		case (new_width)
			`DEV_WIDTH_32: lane_n = ~req_byte_en;
			`DEV_WIDTH_16: lane_n = {2'b11, ~req_byte_en[1:0]};
			default:       lane_n = {3'b111, ~req_byte_en[0]};
		endcase
	end

	// sequencer next state
	always_comb begin
		next_st       = st;
		next_st.done  = 1'b0;
		next_st.error = 1'b0;
		case (st.phase)
			ph_idle: begin
				// release the bus only between accesses
				if (!release_req_n) begin
					next_st.phase = ph_released;
				end else if (req_valid && !dec_hit) begin
					// no region claims it: answer at once, pins untouched
					next_st.error = 1'b1;
				end else if (req_valid) begin
					next_st.phase  = ph_addr;
					next_st.region = dec_index;
					next_st.write  = req_write;
					next_st.addr   = req_addr;
					next_st.wdata  = req_wdata;
					next_st.bc_n   = lane_n;
					// address phase length programmed per region
					next_st.count  = {1'b0, ale_cycles[dec_index*`PHASE_CNT_W +: `PHASE_CNT_W]};
				end
			end
			// a count of zero runs as one cycle
			ph_addr: begin
				if (st.count > 1) begin
					next_st.count = st.count - 1'b1;
				end else begin
					next_st.phase = ph_cmd;
					next_st.count = {1'b0,
						cmd_phase_cycles[st.region*`PHASE_CNT_W +: `PHASE_CNT_W]};
				end
			end
			ph_cmd: begin
				// programmed cycles run out before extension is looked at
				if (st.count > 1) begin
					next_st.count = st.count - 1'b1;
				// sampled extension request holds the phase
				end else if (!cmd_ext) begin
					next_st.phase = ph_access;
					next_st.count = st.write ?
						write_wait_cycles[st.region*`WAIT_CNT_W +: `WAIT_CNT_W] :
						read_wait_cycles[st.region*`WAIT_CNT_W +: `WAIT_CNT_W];
				end
			end
			ph_access: begin
				// fixed wait states first, then the sampled wait level
				if (st.count > 1) begin
					next_st.count = st.count - 1'b1;
				end else if (!wait_act) begin
					next_st.phase = ph_recover;
					// read lines are captured at the edge that ends the strobe
					next_st.rdata = st.write ? st.rdata : ad_in;
					next_st.done  = 1'b1;
				end
			end
			ph_recover: begin
				// one idle cycle keeps selects of back-to-back accesses apart
				next_st.phase = ph_idle;
			end
			ph_released: begin
				if (release_req_n) begin
					next_st.phase = ph_idle;
				end
			end
			default: begin
				next_st.phase = ph_idle;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st       <= '0;
			// lanes idle high so no byte is enabled out of reset
			st.phase <= ph_idle;
			st.bc_n  <= `BC_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// request side handshake and answers
	// a pending release request holds ready low
	assign req_ready  = (st.phase == ph_idle) && release_req_n;
	assign resp_done  = st.done;
	assign resp_error = st.error;
	assign resp_rdata = st.rdata;

	// strobe windows
	// the recovery cycle keeps every select high
	assign select_on = (st.phase == ph_addr) || (st.phase == ph_cmd) ||
		(st.phase == ph_access);
	assign strobe_on = (st.phase == ph_access);

	// latch strobe high in the address phase of muxed regions only
	// strobe only in the address phase, so it never overlaps data
	assign ale     = (st.phase == ph_addr) && cur_muxed;
	assign rd_n    = !(strobe_on && !st.write);
	assign rd_wr_n = !(strobe_on && st.write);

	// lane enables follow select, either strobe, or the write strobe
	// an unknown timing code keeps every lane off
	always_comb begin
		case (region_bc_timing[st.region*2 +: 2])
			`BCT_CHIP_SEL:   byte_lane_enable_n = select_on ? st.bc_n : `BC_IDLE;
			`BCT_CONTROL:    byte_lane_enable_n = strobe_on ? st.bc_n : `BC_IDLE;
			`BCT_WRITE_ONLY: byte_lane_enable_n =
				(strobe_on && st.write) ? st.bc_n : `BC_IDLE;
			default:         byte_lane_enable_n = `BC_IDLE;
		endcase
	end

	// one select, from the single winning region of the access
	for (genvar r = 0; r < REGIONS; r++) begin : g_cs
		assign user_chip_select_n[r] = !(select_on && (st.region == r));
	end

	// global select is active while any chosen user select is
	// unmasked selects can never pull it low
	assign global_chip_select_n = &(user_chip_select_n | ~global_select_mask);

	// muxed lines carry the address first, then write data or float
	// write data stands from the command phase on, for setup time
	assign ad_out   = (st.phase == ph_addr && cur_muxed) ? st.addr : st.wdata;
	assign ad_oe    = (st.phase == ph_addr && cur_muxed) ||
		((st.phase == ph_cmd || st.phase == ph_access) && st.write);
	assign addr_out = st.addr[23:0];
	assign addr_oe  = (st.phase != ph_released);

	// acknowledge while released; ask for the bus when work waits
	// the ownership request is combinational so it follows req_valid at once
	assign bus_release_ack_n       = !(st.phase == ph_released);
	assign bus_ownership_request_n = !((st.phase == ph_released) && req_valid);

endmodule : ext_bus_control

// File: ext_bus_control_assertions.sv
// port-level checks for the external bus control block
`timescale 1ns/1ns
`include "ext_ctl_defs.svh"
module ext_bus_control_assertions #(
	parameter int REGIONS = `REGION_COUNT
) (
	// clock and reset
	input wire logic                   clock,
	input wire logic                   rst_n,
	// region setup
	input wire logic [REGIONS-1:0]     global_select_mask,
	input wire logic [REGIONS-1:0]     region_muxed,
	input wire logic [REGIONS*2-1:0]   region_dev_width,
	input wire logic [REGIONS*2-1:0]   region_bc_timing,
	// strobes and selects
	input wire logic                   ale,
	input wire logic                   ad_oe,
	input wire logic                   addr_oe,
	input wire logic                   rd_n,
	input wire logic                   rd_wr_n,
	input wire logic [3:0]             byte_lane_enable_n,
	input wire logic [REGIONS-1:0]     user_chip_select_n,
	input wire logic                   global_chip_select_n,
	// release handshake
	input wire logic                   release_req_n,
	input wire logic                   bus_release_ack_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic       cs_any;  // some user select is low
	logic [1:0] sel_w;   // width code of the selected region
	logic [1:0] sel_t;   // lane timing code of the selected region
	logic       sel_mx;  // selected region is multiplexed
	// look up the setup of whichever region is selected
	always_comb begin
		sel_w = 2'h0;
		sel_t = 2'h0;
		sel_mx = 1'b0;
		for (int r = REGIONS - 1; r >= 0; r--) begin
			if (!user_chip_select_n[r]) begin
				sel_w = region_dev_width[r*2+:2];
				sel_t = region_bc_timing[r*2+:2];
				sel_mx = region_muxed[r];
			end
		end
	end
	assign cs_any = ~&user_chip_select_n;
	property p_cs_onehot;
		$onehot0(~user_chip_select_n);
	endproperty
	a_cs_onehot: assert property (p_cs_onehot) else $error("two user selects low");
	property p_gcs;
		global_chip_select_n == !(|(~user_chip_select_n & global_select_mask));
	endproperty
	a_gcs: assert property (p_gcs) else $error("global select wrong");
	property p_ale_muxed;
		ale |-> cs_any && sel_mx;
	endproperty
	a_ale_muxed: assert property (p_ale_muxed) else $error("strobe outside muxed");
	property p_ale_addr;
		ale |-> ad_oe && rd_n && rd_wr_n;
	endproperty
	a_ale_addr: assert property (p_ale_addr) else $error("address phase wrong");
	property p_lane_width;
		cs_any |-> (sel_w != `DEV_WIDTH_8 || byte_lane_enable_n[3:1] == 3'h7)
			&& (sel_w != `DEV_WIDTH_16 || byte_lane_enable_n[3:2] == 2'h3);
	endproperty
	a_lane_width: assert property (p_lane_width) else $error("lane for width");
	property p_lane_ctl;
		(byte_lane_enable_n != `BC_IDLE && sel_t == `BCT_CONTROL) |-> !rd_n || !rd_wr_n;
	endproperty
	a_lane_ctl: assert property (p_lane_ctl) else $error("lane outside strobe");
	property p_lane_wr;
		(byte_lane_enable_n != `BC_IDLE && sel_t == `BCT_WRITE_ONLY) |-> !rd_wr_n;
	endproperty
	a_lane_wr: assert property (p_lane_wr) else $error("lane outside write");
	property p_release;
		!bus_release_ack_n |-> user_chip_select_n == `CS_IDLE && !addr_oe;
	endproperty
	a_release: assert property (p_release) else $error("bus used while released");
	property p_ack;
		$fell(bus_release_ack_n) |-> $past(release_req_n) == 1'b0;
	endproperty
	a_ack: assert property (p_ack) else $error("release without request");
	property p_ack_end;
		!bus_release_ack_n && release_req_n |=> bus_release_ack_n;
	endproperty
	a_ack_end: assert property (p_ack_end) else $error("release held too long");
endmodule : ext_bus_control_assertions
bind ext_bus_control ext_bus_control_assertions #(.REGIONS(REGIONS)) chk_u (.clock, .rst_n,
	.global_select_mask, .region_muxed, .region_dev_width, .region_bc_timing, .ale, .ad_oe,
	.addr_oe, .rd_n, .rd_wr_n, .byte_lane_enable_n, .user_chip_select_n,
	.global_chip_select_n, .release_req_n, .bus_release_ack_n);

// File: ext_bus_partner.sv
// external memory and bus master standing on the far side of the pins
`timescale 1ns/1ns
module ext_bus_partner #(
	parameter logic [31:0] RD_PATTERN = 32'h5a3c_c3a5
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// pins from the block
	input wire logic [6:0]  user_chip_select_n,
	input wire logic        ale,
	input wire logic        rd_n,
	input wire logic        rd_wr_n,
	input wire logic [31:0] ad_out,
	input wire logic        ad_oe,
	// pins to the block
	output logic [31:0]     ad_in,
	output logic            cmd_extend_input,
	output logic            wait_input,
	output logic            release_req_n,
	// commands from the bench
	input wire logic [3:0]  stretch,
	input wire logic        wait_pol,
	input wire logic        hold_req,
	// what the device saw
	output logic [31:0]     lat_addr,
	output logic [31:0]     wr_data
);
	logic [3:0] cnt;     // cycles since select went low
	logic       active;  // device still busy
	// count select cycles, restart between accesses
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
		end else if (&user_chip_select_n) begin
			cnt <= 4'h0;
		end else if (cnt != 4'hf) begin
			cnt <= cnt + 4'h1;
		end
	end
	assign active = cnt < stretch;
	assign cmd_extend_input = active;
	assign wait_input = active ? wait_pol : ~wait_pol;
	assign release_req_n = ~hold_req;
	// lines float to the pull-up level when nobody drives
	assign ad_in = ad_oe ? ad_out : (!rd_n && !(&user_chip_select_n)) ? RD_PATTERN : '1;
	// transparent latch and write capture, read just before each edge
	always_ff @(posedge clock) begin
		if (ale) lat_addr <= ad_in;
		if (!rd_wr_n) wr_data <= ad_in;
	end
endmodule : ext_bus_partner

// File: ext_bus_control_test.sv
// self-checking bench for the external bus control block
`timescale 1ns/1ns
`include "ext_ctl_defs.svh"
module ext_bus_control_test;
	localparam logic [31:0] PAT = 32'hc3a5_0f69;  // read data the device returns
	logic clock, rst_n, req_valid, req_write, req_ready, resp_done, resp_error;
	logic [31:0] req_addr, req_wdata, resp_rdata, ad_out, ad_in, lat_addr, wr_data;
	logic [3:0] req_byte_en, byte_lane_enable_n, stretch, bc_s;
	logic [6:0] region_enable, global_select_mask, region_muxed, user_chip_select_n, cs_s;
	logic [6:0] wait_enable, wait_polarity_select, wait_async;
	logic [139:0] region_base, region_mask;
	logic [13:0] region_dev_width, region_bc_timing, cmd_extend_sample_mode;
	logic [27:0] ale_cycles, cmd_phase_cycles;
	logic [34:0] read_wait_cycles, write_wait_cycles;
	logic [23:0] addr_out;
	logic addr_oe, ad_oe, ale, rd_n, rd_wr_n, global_chip_select_n, gcs_s, err_s;
	logic cmd_extend_input, wait_input, release_req_n, bus_release_ack_n;
	logic bus_ownership_request_n, wait_pol, hold_req;
	int n_mismatch, checks_done, cyc, alen, e, i;
	int md[6] = '{1, 2, 0, 1, 0, 0};  // command-extend sampling mode
	int we[6] = '{0, 0, 0, 0, 1, 1};  // wait enabled
	int wa[6] = '{0, 0, 0, 0, 0, 1};  // wait sampled asynchronously
	int wp[6] = '{1, 1, 1, 1, 1, 0};  // wait polarity
	int nn[6] = '{4, 4, 4, 0, 5, 5};  // cycles the device stays busy
	ext_bus_control dut_u (.clock, .rst_n, .req_valid, .req_ready, .req_write, .req_addr,
		.req_wdata, .req_byte_en, .resp_done, .resp_error, .resp_rdata, .region_enable,
		.region_base, .region_mask, .global_select_mask, .region_muxed, .region_dev_width,
		.region_bc_timing, .cmd_extend_sample_mode, .wait_enable, .wait_polarity_select,
		.wait_async, .ale_cycles, .cmd_phase_cycles, .read_wait_cycles, .write_wait_cycles,
		.addr_out, .addr_oe, .ad_out, .ad_oe, .ad_in, .ale, .rd_n, .rd_wr_n,
		.byte_lane_enable_n, .user_chip_select_n, .global_chip_select_n, .cmd_extend_input,
		.wait_input, .release_req_n, .bus_release_ack_n, .bus_ownership_request_n);
	ext_bus_partner #(.RD_PATTERN(PAT)) partner_u (.clock, .rst_n, .user_chip_select_n,
		.ale, .rd_n, .rd_wr_n, .ad_out, .ad_oe, .ad_in, .cmd_extend_input, .wait_input,
		.release_req_n, .stretch, .wait_pol, .hold_req, .lat_addr, .wr_data);
	// free-running clock, 50 ns period
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// one region's bus control and access parameters
	task automatic cfg(input int r, input logic mx, input logic [1:0] w, input logic [1:0] t,
			input logic [3:0] a, input logic [3:0] c, input logic [4:0] wt);
		region_muxed[r] = mx;
		region_dev_width[r*2+:2] = w;
		region_bc_timing[r*2+:2] = t;
		ale_cycles[r*4+:4] = a;
		cmd_phase_cycles[r*4+:4] = c;
		read_wait_cycles[r*5+:5] = wt;
		write_wait_cycles[r*5+:5] = wt;
	endtask : cfg
	// one access: hold the request until taken, then watch the pins until done
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
			input logic [3:0] be);
		int k;
		@(negedge clock);
		{req_valid, req_write, req_addr, req_wdata, req_byte_en} = {1'b1, w, a, d, be};
		k = 0;
		while (req_ready !== 1'b1 && k < 40) begin
			@(negedge clock);
			k++;
		end
		@(negedge clock);
		req_valid = 1'b0;
		{cyc, alen, cs_s, gcs_s, bc_s} = {32'd0, 32'd0, 7'h7f, 1'b1, 4'hf};
		while (k < 40 && cyc < 60) begin
			if (resp_done === 1'b1 || resp_error === 1'b1) break;
			cyc++;
			cs_s &= user_chip_select_n;
			gcs_s &= global_chip_select_n;
			bc_s &= byte_lane_enable_n;
			alen += int'(ale);
			@(negedge clock);
		end
		err_s = resp_error;
		if (k >= 40 || cyc >= 60) begin
			n_mismatch++;
			end_of_test();
		end
	endtask : acc
	// main sequence
	initial begin
		{rst_n, req_valid, req_write, req_addr, req_wdata, req_byte_en} = '0;
		{wait_enable, wait_polarity_select, wait_async, cmd_extend_sample_mode} = '0;
		{stretch, wait_pol, hold_req, region_base, region_mask} = '0;
		{region_enable, global_select_mask} = {7'h07, 7'h02};
		region_base[59:0] = {20'ha_0000, 20'h8_0000, 20'h8_0000};
		region_mask[59:0] = {20'hf_ffff, 20'hf_f000, 20'hf_ff00};
		for (int r = 0; r < 7; r++) cfg(r, 1'b1, `DEV_WIDTH_32, `BCT_CONTROL, 4'h1, 4'h2, 5'h2);
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		chk("idle selects", user_chip_select_n, `CS_IDLE);
		cfg(0, 1'b1, `DEV_WIDTH_32, `BCT_CONTROL, 4'h3, 4'h2, 5'h2);
		acc(1'b0, 32'h8000_0010, 32'h0, 4'hf);
		chk("cycles", cyc, 7);
		chk("overlap select", cs_s, 7'h7e);
		chk("global off", gcs_s, 1'b1);
		chk("latch length", alen, 3);
		chk("latched addr", lat_addr[25:0], 26'h000_0010);
		chk("address lines", addr_out, 24'h00_0010);
		chk("read data", resp_rdata, PAT);
		chk("lanes", bc_s, 4'h0);
		cfg(1, 1'b1, `DEV_WIDTH_16, `BCT_CHIP_SEL, 4'h1, 4'h2, 5'h2);
		acc(1'b1, 32'h8010_0020, 32'h1234_abcd, 4'hf);
		chk("select 1", cs_s, 7'h7d);
		chk("global on", gcs_s, 1'b0);
		chk("lanes 16", bc_s, 4'hc);
		chk("write data", wr_data[15:0], 16'habcd);
		cfg(2, 1'b0, `DEV_WIDTH_8, `BCT_WRITE_ONLY, 4'h2, 4'h2, 5'h2);
		acc(1'b1, 32'ha000_0003, 32'h0000_0077, 4'hf);
		chk("no strobe", alen, 0);
		chk("lanes 8", bc_s, 4'he);
		chk("byte data", wr_data[7:0], 8'h77);
		cfg(0, 1'b1, `DEV_WIDTH_32, `BCT_WRITE_ONLY, 4'h1, 4'h2, 5'h2);
		acc(1'b1, 32'h8000_0020, 32'h5555_aaaa, 4'h5);
		chk("lanes sparse", bc_s, 4'ha);
		acc(1'b0, 32'hc000_0000, 32'h0, 4'hf);
		chk("no region", {err_s, cs_s}, {1'b1, 7'h7f});
		// at least two command and wait cycles
		cfg(0, 1'b1, `DEV_WIDTH_32, `BCT_CONTROL, 4'h1, 4'h2, 5'h2);
		for (i = 0; i < 6; i++) begin
			cmd_extend_sample_mode[1:0] = md[i][1:0];
			{wait_enable[0], wait_async[0]} = {we[i][0], wa[i][0]};
			{wait_polarity_select[0], wait_pol, stretch} = {wp[i][0], wp[i][0], nn[i][3:0]};
			e = md[i] == 0 ? 3 : nn[i] + 1 + md[i] > 3 ? nn[i] + 1 + md[i] : 3;
			e += 2;
			if (we[i] != 0 && nn[i] + 2 + wa[i] > e) e = nn[i] + 2 + wa[i];
			acc(1'b0, 32'h8000_0040, 32'h0, 4'hf);
			chk("extended cycles", cyc, e);
		end
		{stretch, wait_enable} = '0;
		@(negedge clock);
		hold_req = 1'b1;
		i = 0;
		while (bus_release_ack_n !== 1'b0 && i < 10) begin
			@(negedge clock);
			i++;
		end
		chk("release delay", i, 1);
		chk("address off", addr_oe, 1'b0);
		req_valid = 1'b1;
		#1;
		chk("ownership", {bus_ownership_request_n, req_ready}, 2'b00);
		@(negedge clock);
		{req_valid, hold_req} = 2'b00;
		repeat (2) @(negedge clock);
		chk("released end", bus_release_ack_n, 1'b1);
		acc(1'b0, 32'h8000_0010, 32'h0, 4'hf);
		chk("after release", cyc, 5);
		end_of_test();
	end
endmodule : ext_bus_control_test
